// [sfpes_pkg.sv]
// Shared constants and types for the flash command sequencer.
// Assumes one 50 MHz system clock and 24-bit command addresses.
package sfpes_pkg;

  // ==========
  // Command codes.
  localparam logic [7:0] OPC_WREN = 8'h06; // Sets the write latch.
  localparam logic [7:0] OPC_WRDI = 8'h04; // Clears the write latch.
  localparam logic [7:0] OPC_PP1  = 8'h02; // Single-line page program.
  localparam logic [7:0] OPC_PP4  = 8'h32; // Quad-input page program.
  localparam logic [7:0] OPC_SE   = 8'h20; // Sector erase.
  localparam logic [7:0] OPC_BE32 = 8'h52; // Half block erase.
  localparam logic [7:0] OPC_BE64 = 8'hD8; // Block erase.
  localparam logic [7:0] OPC_CE1  = 8'hC7; // Chip erase.
  localparam logic [7:0] OPC_CE2  = 8'h60; // Chip erase, alias.
  localparam logic [7:0] OPC_SUSP = 8'h75; // Suspend.
  localparam logic [7:0] OPC_RESM = 8'h7A; // Resume.

  // ==========
  // Frame shape, in bits seen on the link.
  localparam logic [5:0] OPC_BITS = 6'h08; // Opcode only.
  localparam logic [5:0] HDR_BITS = 6'h20; // Opcode plus address.

  // ==========
  // Area sizes as log2 of bytes, and protection units.
  localparam logic [4:0]  LG_PAGE  = 5'h08;
  localparam logic [4:0]  LG_SECT  = 5'h0C;
  localparam logic [4:0]  LG_B32   = 5'h0F;
  localparam logic [4:0]  LG_B64   = 5'h10;
  localparam logic [24:0] SEC_UNIT = 25'h0001000; // Fine unit, 4 KB.
  localparam logic [24:0] BLK_UNIT = 25'h0010000; // Coarse unit, 64 KB.
  localparam logic [24:0] SEC_CAP  = 25'h0008000; // Fine range ceiling.

  // ==========
  // Timing.
  localparam int CLK_MHZ    = 50;
  localparam int TSUS_NS    = 20000; // Suspend latency.
  localparam int TSUS_CYC   = (TSUS_NS * CLK_MHZ) / 1000;
  localparam int RESUME_NS  = 200;   // Resume to busy.
  localparam int RESUME_CYC = (RESUME_NS * CLK_MHZ) / 1000;

  // Kind of self-timed operation.
  typedef enum logic [2:0] {
    KIND_PROG, KIND_SECT, KIND_B32, KIND_B64, KIND_CHIP
  } sfpes_kind_t;

  // Sequencer state.
  typedef enum logic {ST_IDLE, ST_RUN} sfpes_state_t;

endpackage : sfpes_pkg

// [sfpes_top.sv]
// Program, erase and suspend sequencer of a serial NOR flash.
// Assumes the host drives chip select, serial clock and four data lines;
// the array itself and the lock table sit outside this module.
`timescale 1ns/1ps
module sfpes_top
#(
  parameter int ADDR_W  = 22,       // Array size as log2 of bytes.
  parameter int PROG_US = 700,      // Page program time.
  parameter int SECT_US = 45000,    // Sector erase time.
  parameter int B32_US  = 120000,   // Half block erase time.
  parameter int B64_US  = 150000,   // Block erase time.
  parameter int CHIP_US = 10000000  // Chip erase time.
)
(
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        cs_n_pin,
  input  wire logic        sclk_pin,
  input  wire logic [3:0]  io_pin,
  input  wire logic        quad_enable_bit,
  input  wire logic        protect_complement,
  input  wire logic        protect_granularity,
  input  wire logic        protect_top_bottom,
  input  wire logic        protect_range_bit2,
  input  wire logic        protect_range_bit1,
  input  wire logic        protect_range_bit0,
  input  wire logic        lock_hit,
  input  wire logic        any_lock,
  output logic             busy,
  output logic             suspend_flag,
  output logic             write_enable_latch,
  output logic [23:0]      lock_query_addr,
  output logic             mem_wr_en,
  output logic [23:0]      mem_wr_addr,
  output logic [7:0]       mem_wr_data,
  output logic             mem_erase_en,
  output logic [23:0]      mem_erase_addr,
  output logic [4:0]       mem_erase_lg
);

  localparam logic [24:0] SIZE     = 25'h1 << ADDR_W;
  localparam logic [31:0] PROG_CYC = 32'(PROG_US * sfpes_pkg::CLK_MHZ);
  localparam logic [31:0] SECT_CYC = 32'(SECT_US * sfpes_pkg::CLK_MHZ);
  localparam logic [31:0] B32_CYC  = 32'(B32_US * sfpes_pkg::CLK_MHZ);
  localparam logic [31:0] B64_CYC  = 32'(B64_US * sfpes_pkg::CLK_MHZ);
  localparam logic [31:0] CHIP_CYC = 32'(CHIP_US * sfpes_pkg::CLK_MHZ);
  localparam int          SUS_LIM  = sfpes_pkg::TSUS_CYC;
  localparam int          RES_LIM  = sfpes_pkg::RESUME_CYC;

  // ==========
  // Pin synchronisers: {chip select, serial clock, data}.
  logic [5:0] s1_reg;   // First stage, read only by the second.
  logic [5:0] s2_reg;   // Settled pin levels.
  logic [5:0] s3_reg;   // One cycle older, for edge finding.
  logic       cs_low;   // Frame in progress.
  logic       cs_fall;  // Frame opens.
  logic       end_ev;   // Frame closes.
  logic       sck_rise; // Sequencer latches a bit.

  // Three plain stages; the link clock is only sampled, never used.
  always_ff @(posedge clock)
  begin
    s1_reg <= {cs_n_pin, sclk_pin, io_pin};
    s2_reg <= s1_reg;
    s3_reg <= s2_reg;
  end

  assign cs_low   = !s2_reg[5];
  assign cs_fall  = !s2_reg[5] && s3_reg[5];
  assign end_ev   = s2_reg[5] && !s3_reg[5];
  assign sck_rise = s2_reg[4] && !s3_reg[4] && cs_low;

  // ==========
  // Frame shifter and page buffer.
  logic [5:0]   bcnt_reg, bcnt_next;   // Header bits taken.
  logic [2:0]   sub_reg, sub_next;     // Bits into current data byte.
  logic [7:0]   opc_reg, opc_next;     // Opcode.
  logic [7:0]   sh_reg, sh_next;       // Data byte assembly.
  logic [23:0]  addr_reg, addr_next;   // Command address.
  logic [7:0]   bidx_reg, bidx_next;   // Data bytes taken, modulo page.
  logic         got_reg, got_next;     // At least one whole byte.
  logic [255:0] valid_reg, valid_next; // Page slots loaded.
  logic         buf_we;                // Page buffer write strobe.
  logic [7:0]   widx;                  // Page slot being written.
  logic [7:0]   pbuf [256];            // Page buffer.
  logic         busy_reg;              // Self-timed operation running.

  // Header bits stack up until the opcode and address are in; after
  // that every whole byte lands in the page buffer. The buffer is frozen
  // while busy so a stray frame cannot corrupt data being programmed.
  always_comb
  begin
    bcnt_next  = bcnt_reg;
    sub_next   = sub_reg;
    opc_next   = opc_reg;
    sh_next    = sh_reg;
    addr_next  = addr_reg;
    bidx_next  = bidx_reg;
    got_next   = got_reg;
    valid_next = valid_reg;
    buf_we     = 1'b0;
    widx       = addr_reg[7:0] + bidx_reg;
    if (cs_fall)
    begin
      bcnt_next = '0;
      sub_next  = '0;
      bidx_next = '0;
      // A short frame, such as chip erase, must not reuse an old address.
      addr_next = '0;
      got_next  = 1'b0;
      if (!busy_reg)
        valid_next = '0;
    end
    else if (sck_rise)
    begin
      if (bcnt_reg < sfpes_pkg::OPC_BITS)
      begin
        opc_next  = {opc_reg[6:0], s2_reg[0]};
        bcnt_next = bcnt_reg + 6'h01;
      end
      else if (bcnt_reg < sfpes_pkg::HDR_BITS)
      begin
        // Quad program carries the address on all four lines.
        if (opc_reg == sfpes_pkg::OPC_PP4)
        begin
          addr_next = {addr_reg[19:0], s2_reg[3:0]};
          bcnt_next = bcnt_reg + 6'h04;
        end
        else
        begin
          addr_next = {addr_reg[22:0], s2_reg[0]};
          bcnt_next = bcnt_reg + 6'h01;
        end
      end
      else
      begin
        if (opc_reg == sfpes_pkg::OPC_PP4)
        begin
          sh_next  = {sh_reg[3:0], s2_reg[3:0]};
          sub_next = sub_reg + 3'h4;
        end
        else
        begin
          sh_next  = {sh_reg[6:0], s2_reg[0]};
          sub_next = sub_reg + 3'h1;
        end
        // A whole byte goes to its slot; later bytes overwrite earlier.
        if (sub_next == 3'h0)
        begin
          got_next  = 1'b1;
          bidx_next = bidx_reg + 8'h01;
          if (!busy_reg)
          begin
            buf_we           = 1'b1;
            valid_next[widx] = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      bcnt_reg  <= '0;
      sub_reg   <= '0;
      opc_reg   <= '0;
      sh_reg    <= '0;
      addr_reg  <= '0;
      bidx_reg  <= '0;
      got_reg   <= 1'b0;
      valid_reg <= '0;
    end
    else
    begin
      bcnt_reg  <= bcnt_next;
      sub_reg   <= sub_next;
      opc_reg   <= opc_next;
      sh_reg    <= sh_next;
      addr_reg  <= addr_next;
      bidx_reg  <= bidx_next;
      got_reg   <= got_next;
      valid_reg <= valid_next;
    end
  end

  // Buffer contents need no reset; the valid mask guards them.
  always_ff @(posedge clock)
  begin
    if (buf_we)
      pbuf[widx] <= sh_next;
  end

  // ==========
  // Area checks.
  // Protected range from the range bits; complement inverts it.
  function automatic logic prot_hit(input logic [23:0] a,
                                    input logic [4:0]  lg);
    logic [2:0]  bp;
    logic [24:0] len;
    logic [24:0] lo;
    logic [24:0] hi;
    logic [24:0] ta;
    logic [24:0] te;
    bp  = {protect_range_bit2, protect_range_bit1, protect_range_bit0};
    len = '0;
    if (bp != 3'h0)
      len = (protect_granularity ? sfpes_pkg::SEC_UNIT
                                 : sfpes_pkg::BLK_UNIT) << (bp - 3'h1);
    if (protect_granularity && len > sfpes_pkg::SEC_CAP)
      len = sfpes_pkg::SEC_CAP;
    if (len > SIZE)
      len = SIZE;
    lo = protect_top_bottom ? '0 : SIZE - len;
    hi = protect_top_bottom ? len : SIZE;
    ta = {1'b0, a} & (SIZE - 25'h1) & ~((25'h1 << lg) - 25'h1);
    te = ta + (25'h1 << lg);
    if (protect_complement)
      return !(ta >= lo && te <= hi);
    return ta < hi && te > lo;
  endfunction : prot_hit

  // Two aligned areas meet when they agree above the larger size.
  function automatic logic same_area(input logic [23:0] a,
                                     input logic [4:0]  la,
                                     input logic [23:0] b,
                                     input logic [4:0]  lb);
    logic [4:0] m;
    m = (la > lb) ? la : lb;
    return ((a ^ b) >> m) == 24'h0;
  endfunction : same_area

  // ==========
  // Command decode at frame end.
  sfpes_pkg::sfpes_kind_t kind;   // Kind the opcode asks for.
  logic [4:0]             lg;     // Its area size.
  logic [31:0]            dur;    // Its run time in cycles.
  logic                   isop;   // Opcode is program or erase.
  logic                   shape;  // Frame ended cleanly.
  logic                   prot;   // Target protected or locked.
  logic                   forbid; // Barred while suspended.
  logic                   go_op, acc_sus, acc_res, one_byte;
  sfpes_pkg::sfpes_kind_t skind_reg;
  logic [23:0]            saddr_reg;
  logic [4:0]             slg_reg;
  logic                   sus_reg;
  logic                   wel_reg;
  sfpes_pkg::sfpes_kind_t kind_reg;

  always_comb
  begin
    kind     = sfpes_pkg::KIND_PROG;
    lg       = sfpes_pkg::LG_PAGE;
    dur      = PROG_CYC;
    isop     = 1'b1;
    one_byte = bcnt_reg == sfpes_pkg::OPC_BITS;
    // A sector or block erase frame must end on its last address bit; any stray bit
    // after it leaves a part or whole byte behind and cancels the command.
    shape    = bcnt_reg == sfpes_pkg::HDR_BITS && sub_reg == 3'h0 &&
               !got_reg;
    unique case (opc_reg)
      sfpes_pkg::OPC_PP1, sfpes_pkg::OPC_PP4:
        shape = bcnt_reg == sfpes_pkg::HDR_BITS && got_reg &&
                sub_reg == 3'h0 &&
                (opc_reg != sfpes_pkg::OPC_PP4 || quad_enable_bit);
      sfpes_pkg::OPC_SE:
      begin
        kind = sfpes_pkg::KIND_SECT;
        lg   = sfpes_pkg::LG_SECT;
        dur  = SECT_CYC;
      end
      sfpes_pkg::OPC_BE32:
      begin
        kind = sfpes_pkg::KIND_B32;
        lg   = sfpes_pkg::LG_B32;
        dur  = B32_CYC;
      end
      sfpes_pkg::OPC_BE64:
      begin
        kind = sfpes_pkg::KIND_B64;
        lg   = sfpes_pkg::LG_B64;
        dur  = B64_CYC;
      end
      sfpes_pkg::OPC_CE1, sfpes_pkg::OPC_CE2:
      begin
        kind  = sfpes_pkg::KIND_CHIP;
        lg    = 5'(ADDR_W);
        dur   = CHIP_CYC;
        shape = one_byte;
      end
      default:
        isop = 1'b0;
    endcase
    // A whole-array target turns the range test into "anything at all".
    prot = prot_hit(addr_reg, lg) ||
           (kind == sfpes_pkg::KIND_CHIP ? any_lock : lock_hit);
    // Commands of the suspended class (program or erase) are barred; others must miss the held area.
    forbid = sus_reg &&
             (((skind_reg == sfpes_pkg::KIND_PROG) ==
               (kind == sfpes_pkg::KIND_PROG)) ||
              same_area(addr_reg, lg, saddr_reg, slg_reg));
    go_op = end_ev && isop && shape && wel_reg &&
            !busy_reg && !prot && !forbid;
    acc_sus = end_ev && one_byte && opc_reg == sfpes_pkg::OPC_SUSP &&
              busy_reg && !sus_reg &&
              kind_reg != sfpes_pkg::KIND_CHIP;
    acc_res = end_ev && one_byte && opc_reg == sfpes_pkg::OPC_RESM &&
              sus_reg && !busy_reg;
  end

  // ==========
  // Sequencer.
  sfpes_pkg::sfpes_state_t st_reg, st_next;
  sfpes_pkg::sfpes_kind_t  kind_next, skind_next;
  logic        busy_next, sus_next, wel_next, pend_reg, pend_next;
  logic [31:0] left_reg, left_next, sleft_reg, sleft_next;
  logic [23:0] oaddr_reg, oaddr_next, saddr_next;
  logic [4:0]  olg_reg, olg_next, slg_next;
  logic [8:0]  scan_reg, scan_next; // Top bit set once all slots sent.
  logic        wr_en_next, er_en_next;
  logic [23:0] wr_addr_next, er_addr_next;
  logic [7:0]  wr_data_next;
  logic [4:0]  er_lg_next;
  logic        wr_en_reg, er_en_reg;
  logic [23:0] wr_addr_reg, er_addr_reg;
  logic [7:0]  wr_data_reg;
  logic [4:0]  er_lg_reg;

  // A program first streams its loaded slots out, one per cycle, and
  // then waits out its timer. A suspend is flagged at once but parks the
  // operation only after that stream, well inside the latency limit.
  always_comb
  begin
    st_next      = st_reg;
    kind_next    = kind_reg;
    skind_next   = skind_reg;
    sus_next     = sus_reg;
    wel_next     = wel_reg;
    pend_next    = pend_reg;
    left_next    = left_reg;
    sleft_next   = sleft_reg;
    oaddr_next   = oaddr_reg;
    saddr_next   = saddr_reg;
    olg_next     = olg_reg;
    slg_next     = slg_reg;
    scan_next    = scan_reg;
    wr_en_next   = 1'b0;
    er_en_next   = 1'b0;
    wr_addr_next = {oaddr_reg[23:8], scan_reg[7:0]};
    wr_data_next = pbuf[scan_reg[7:0]];
    er_addr_next = oaddr_reg & (24'hFFFFFF << olg_reg);
    er_lg_next   = olg_reg;
    if (end_ev && one_byte && !busy_reg)
    begin
      if (opc_reg == sfpes_pkg::OPC_WREN)
        wel_next = 1'b1;
      else if (opc_reg == sfpes_pkg::OPC_WRDI)
        wel_next = 1'b0;
    end
    unique case (st_reg)
      sfpes_pkg::ST_IDLE:
        if (go_op)
        begin
          st_next    = sfpes_pkg::ST_RUN;
          kind_next  = kind;
          oaddr_next = addr_reg;
          olg_next   = lg;
          left_next  = dur;
          scan_next  = (kind == sfpes_pkg::KIND_PROG) ? 9'h000 : 9'h100;
        end
        else if (acc_res)
        begin
          st_next    = sfpes_pkg::ST_RUN;
          sus_next   = 1'b0;
          kind_next  = skind_reg;
          oaddr_next = saddr_reg;
          olg_next   = slg_reg;
          left_next  = sleft_reg;
          scan_next  = 9'h100;
        end
      sfpes_pkg::ST_RUN:
      begin
        if (!scan_reg[8])
        begin
          wr_en_next = valid_reg[scan_reg[7:0]];
          scan_next  = scan_reg + 9'h001;
        end
        if (left_reg != 32'h0)
          left_next = left_reg - 32'h1;
        if (scan_reg[8] && pend_reg)
        begin
          st_next    = sfpes_pkg::ST_IDLE;
          pend_next  = 1'b0;
          skind_next = kind_reg;
          saddr_next = oaddr_reg;
          slg_next   = olg_reg;
          sleft_next = left_reg;
        end
        // A suspend taken on the final cycle parks next cycle with no
        // time left, so the saved state always matches the flag.
        else if (scan_reg[8] && left_reg == 32'h0 && !acc_sus)
        begin
          st_next    = sfpes_pkg::ST_IDLE;
          wel_next   = 1'b0;
          er_en_next = kind_reg != sfpes_pkg::KIND_PROG;
        end
      end
    endcase
    if (acc_sus)
    begin
      sus_next  = 1'b1;
      pend_next = 1'b1;
    end
    busy_next = st_next == sfpes_pkg::ST_RUN;
  end

  // Reset stands for power loss: any suspended work is dropped.
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      st_reg      <= sfpes_pkg::ST_IDLE;
      kind_reg    <= sfpes_pkg::KIND_PROG;
      skind_reg   <= sfpes_pkg::KIND_PROG;
      busy_reg    <= 1'b0;
      sus_reg     <= 1'b0;
      wel_reg     <= 1'b0;
      pend_reg    <= 1'b0;
      left_reg    <= '0;
      sleft_reg   <= '0;
      oaddr_reg   <= '0;
      saddr_reg   <= '0;
      olg_reg     <= '0;
      slg_reg     <= '0;
      scan_reg    <= 9'h100;
      wr_en_reg   <= 1'b0;
      er_en_reg   <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
      er_addr_reg <= '0;
      er_lg_reg   <= '0;
    end
    else
    begin
      st_reg      <= st_next;
      kind_reg    <= kind_next;
      skind_reg   <= skind_next;
      busy_reg    <= busy_next;
      sus_reg     <= sus_next;
      wel_reg     <= wel_next;
      pend_reg    <= pend_next;
      left_reg    <= left_next;
      sleft_reg   <= sleft_next;
      oaddr_reg   <= oaddr_next;
      saddr_reg   <= saddr_next;
      olg_reg     <= olg_next;
      slg_reg     <= slg_next;
      scan_reg    <= scan_next;
      wr_en_reg   <= wr_en_next;
      er_en_reg   <= er_en_next;
      wr_addr_reg <= wr_addr_next;
      wr_data_reg <= wr_data_next;
      er_addr_reg <= er_addr_next;
      er_lg_reg   <= er_lg_next;
    end
  end

  assign busy               = busy_reg;
  assign suspend_flag       = sus_reg;
  assign write_enable_latch = wel_reg;
  assign lock_query_addr    = addr_reg;
  assign mem_wr_en          = wr_en_reg;
  assign mem_wr_addr        = wr_addr_reg;
  assign mem_wr_data        = wr_data_reg;
  assign mem_erase_en       = er_en_reg;
  assign mem_erase_addr     = er_addr_reg;
  assign mem_erase_lg       = er_lg_reg;

  // ==========
  // Checks.
  chk_quad_gate: assert property (@(posedge clock) disable iff (rst)
    go_op && opc_reg == sfpes_pkg::OPC_PP4 |-> quad_enable_bit)
    else $error("quad program taken without quad enable");
  chk_wel_gate: assert property (@(posedge clock) disable iff (rst)
    go_op |-> write_enable_latch)
    else $error("operation taken without write latch");
  chk_busy_start: assert property (@(posedge clock) disable iff (rst)
    go_op |=> busy && !$past(busy))
    else $error("busy did not rise on accepted operation");
  chk_wel_clear: assert property (@(posedge clock) disable iff (rst)
    $fell(busy) && !suspend_flag |-> !write_enable_latch)
    else $error("write latch still set after completion");
  chk_prot_block: assert property (@(posedge clock) disable iff (rst)
    end_ev && isop && prot |=> !$rose(busy))
    else $error("protected area operation started");
  chk_chip_nosus: assert property (@(posedge clock) disable iff (rst)
    busy && kind_reg == sfpes_pkg::KIND_CHIP |=> !$rose(suspend_flag))
    else $error("suspend accepted during chip erase");
  chk_sus_latency: assert property (@(posedge clock) disable iff (rst)
    acc_sus |=> suspend_flag ##[0:SUS_LIM] !busy)
    else $error("suspend flag or busy release late");
  chk_res_busy: assert property (@(posedge clock) disable iff (rst)
    acc_res |=> !suspend_flag ##[0:RES_LIM] busy)
    else $error("resume did not restart in time");
  chk_busy_ignore: assert property (@(posedge clock) disable iff (rst)
    busy && end_ev && isop |=> $stable(oaddr_reg) && $stable(kind_reg))
    else $error("operation taken while busy");
  chk_page_wrap: assert property (@(posedge clock) disable iff (rst)
    mem_wr_en |-> mem_wr_addr[23:8] == oaddr_reg[23:8])
    else $error("program write left its page");

endmodule : sfpes_top

// [sfpes_host_model.sv]
// Host model: drives chip select, serial clock and four data lines.
// Assumes a 50 MHz clock; the serial clock runs at one eighth of it.
`timescale 1ns/1ps
module sfpes_host_model
(
  input  wire logic       clock,
  output logic            cs_n_pin,
  output logic            sclk_pin,
  output logic [3:0]      io_pin
);
  // ==========
  // Frame driver.
  // It sends n1 single-line bits, then nq nibbles, from the top of w.
  // The serial clock stands still outside frames. Released data lines
  // show the inverse of their last value, so stale data cannot pass.
  task automatic frame(input logic [63:0] w, input int n1, input int nq);
    int i;
    cs_n_pin <= 1'b0;
    for (i = 0; i < n1 + nq; i++)
    begin
      repeat (4) @(posedge clock);
      sclk_pin <= 1'b0;
      if (i < n1)
        io_pin <= {~io_pin[3:1], w[63 - i]};
      else
        io_pin <= w[63 - n1 - 4 * (i - n1) -: 4];
      repeat (4) @(posedge clock);
      sclk_pin <= 1'b1;
    end
    repeat (4) @(posedge clock);
    sclk_pin <= 1'b0;
    repeat (4) @(posedge clock);
    cs_n_pin <= 1'b1;
    io_pin   <= ~io_pin;
    repeat (12) @(posedge clock);
  endtask : frame

  // Idle levels from time zero.
  initial
  begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    io_pin   = 4'h0;
  end
endmodule : sfpes_host_model

// [tb_top.sv]
// Self-checking bench for the program, erase and suspend sequencer.
// Assumes the host model above; operation times shortened to 10 us.
`timescale 1ns/1ps
module tb_top;
  logic        clock, rst, qe, lock_hit, any_lock;
  logic [5:0]  prot;     // Complement, granularity, top/bottom, range.
  logic        cs_n_pin, sclk_pin;
  logic [3:0]  io_pin;
  logic        busy, suspend_flag, write_enable_latch;
  logic        mem_wr_en, mem_erase_en;
  logic [23:0] mem_wr_addr, mem_erase_addr, e_addr, w_addr, lqa;
  logic [7:0]  mem_wr_data, wr_seen [256];
  logic [4:0]  mem_erase_lg, e_lg;
  int          n_errors, tests_run, cyc, k;
  logic [7:0]  ops [5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
  logic [23:0] bas [5] = '{24'h123000, 24'h120000, 24'h120000, 0, 0};
  logic [4:0]  lgs [5] = '{5'h0C, 5'h0F, 5'h10, 5'h16, 5'h16};

  sfpes_top #(.PROG_US(10), .SECT_US(10), .B32_US(10), .B64_US(10),
    .CHIP_US(10)) i_sfpes_top (.clock(clock), .rst(rst),
    .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin), .io_pin(io_pin),
    .quad_enable_bit(qe), .protect_complement(prot[5]),
    .protect_granularity(prot[4]), .protect_top_bottom(prot[3]),
    .protect_range_bit2(prot[2]), .protect_range_bit1(prot[1]),
    .protect_range_bit0(prot[0]), .lock_hit(lock_hit),
    .any_lock(any_lock), .busy(busy), .suspend_flag(suspend_flag),
    .write_enable_latch(write_enable_latch), .lock_query_addr(lqa),
    .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .mem_erase_en(mem_erase_en),
    .mem_erase_addr(mem_erase_addr), .mem_erase_lg(mem_erase_lg));
  sfpes_host_model i_sfpes_host_model (.clock(clock), .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin), .io_pin(io_pin));

  // ==========
  // Clock, timeout and array-side capture of the one-cycle pulses.
  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  always @(posedge clock)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      n_errors++;
      summarize();
    end
    if (mem_erase_en === 1'b1)
    begin
      e_addr = mem_erase_addr;
      e_lg   = mem_erase_lg;
    end
    if (mem_wr_en === 1'b1)
    begin
      wr_seen[mem_wr_addr[7:0]] = mem_wr_data;
      w_addr = mem_wr_addr;
    end
  end

  // ==========
  // Access tasks.
  task automatic chk(input string nm, input logic [23:0] ex, got);
    tests_run++;
    if (got !== ex)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic op(input logic [7:0] c, input logic [23:0] a, int n);
    i_sfpes_host_model.frame({c, a, 32'h0}, n, 0);
  endtask : op
  task automatic wop(input logic [7:0] c, input logic [23:0] a, int n);
    op(8'h06, 0, 8);
    op(c, a, n);
  endtask : wop
  // Bounded wait for the end of a self-timed operation.
  task automatic done();
    for (int i = 0; i < 700 && busy !== 1'b0; i++) @(posedge clock);
    chk("busy", 0, busy);
    repeat (2) @(posedge clock);
  endtask : done
  task automatic summarize();
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize

  // ==========
  // Test sequence.
  initial
  begin
    rst = 1'b1; qe = 1'b0; prot = 6'h00; lock_hit = 1'b0; any_lock = 1'b0;
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    repeat (3) @(posedge clock);
    op(8'h20, 24'h001000, 32);
    chk("busy", 0, busy);
    for (k = 0; k < 5; k++)
    begin
      wop(ops[k], 24'h123456, k < 3 ? 32 : 8);
      chk("busy", 1, busy);
      done();
      chk("addr", bas[k], e_addr);
      chk("lg", lgs[k], e_lg);
      chk("wel", 0, write_enable_latch);
    end
    wop(8'h20, 24'h001000, 33);
    chk("busy", 0, busy);
    prot <= 6'h01;
    wop(8'h20, 24'h3F0000, 32);
    chk("busy", 0, busy);
    prot <= 6'h00; lock_hit <= 1'b1;
    op(8'h20, 24'h001000, 32);
    chk("busy", 0, busy);
    chk("lqa", 24'h001000, lqa);
    lock_hit <= 1'b0; any_lock <= 1'b1;
    op(8'hC7, 0, 8);
    chk("busy", 0, busy);
    any_lock <= 1'b0;
    i_sfpes_host_model.frame({8'h32, 24'h0102FF, 16'hAA55, 16'h0}, 8, 10);
    chk("busy", 0, busy);
    qe <= 1'b1;
    i_sfpes_host_model.frame({8'h32, 24'h0102FF, 16'hAA55, 16'h0}, 8, 10);
    chk("busy", 1, busy);
    done();
    chk("wrap0", 8'h55, wr_seen[0]);
    chk("data", 8'hAA, wr_seen[8'hFF]);
    chk("waddr", 24'h0102FF, w_addr);
    wop(8'h20, 24'h002000, 32);
    op(8'h75, 0, 8);
    chk("sus", 1, suspend_flag);
    chk("busy", 0, busy);
    wop(8'hD8, 24'h100000, 32);
    chk("busy", 0, busy);
    op(8'h7A, 0, 8);
    chk("sus", 0, suspend_flag);
    chk("busy", 1, busy);
    done();
    chk("addr", 24'h002000, e_addr);
    repeat (sfpes_pkg::TSUS_CYC) @(posedge clock);
    wop(8'hC7, 0, 8);
    op(8'h75, 0, 8);
    chk("sus", 0, suspend_flag);
    op(8'h20, 24'h001000, 32);
    chk("busy", 1, busy);
    done();
    chk("addr", 0, e_addr);
    wop(8'h20, 24'h003000, 32);
    op(8'h75, 0, 8);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    chk("sus", 0, suspend_flag);
    chk("busy", 0, busy);
    summarize();
  end
endmodule : tb_top
